/* verilog/motion_sensor_consts.vh */
`ifndef MOTION_SENSOR_CONSTS_VH
`define MOTION_SENSOR_CONSTS_VH

// Register offsets
`define ADDR_PRODUCT_IDENT_HIGH        7'h00
`define ADDR_PRODUCT_IDENT_LOW_VERSION 7'h01
`define ADDR_MOVEMENT_FLAGS            7'h02
`define ADDR_HORIZONTAL_DISPLACEMENT   7'h03
`define ADDR_VERTICAL_DISPLACEMENT     7'h04
`define ADDR_POWER_MODE_CONTROL        7'h05
`define ADDR_SENSOR_SETUP              7'h06
`define ADDR_SURFACE_QUALITY           7'h07
`define ADDR_CURRENT_POWER_STATE       7'h08
`define ADDR_WRITE_GUARD               7'h09
`define ADDR_IDLE_ONE_SETUP            7'h0a
`define ADDR_IDLE_ENTRY_DELAY          7'h0b
`define ADDR_IDLE_TWO_SETUP            7'h0c
`define ADDR_SURFACE_QUALITY_LIMIT     7'h0d
`define ADDR_SURFACE_DETECT_SETUP      7'h0e

// Reset values
`define RST_POWER_MODE_CONTROL    8'hb8
`define RST_SENSOR_SETUP          8'h02
`define RST_WRITE_GUARD           8'h00
`define RST_IDLE_ONE_SETUP        8'h70
`define RST_IDLE_ENTRY_DELAY      8'h10
`define RST_IDLE_TWO_SETUP        8'h70
`define RST_SURFACE_QUALITY_LIMIT 8'h0a
`define RST_SURFACE_DETECT_SETUP  8'he5

// Field positions and write guard key
`define PMC_POWER_DOWN    0
`define PMC_IDLE_ONE_EN   3
`define PMC_IDLE_TWO_EN   4
`define PMC_ADAPTIVE_EN   7
`define SDS_GATE_EN       0
`define MVF_MOTION        7
`define MVF_OVF_X         4
`define MVF_OVF_Y         3
`define WRITE_GUARD_OPEN  8'h5a

// Counts per inch codes and values
`define CPI_600   3'h0
`define CPI_800   3'h1
`define CPI_1000  3'h2
`define CPI_1300  3'h3
`define CPI_1600  3'h4

// Timing
`define CLOCK_HZ          100000000
`define FRAME_RATE_HIGH   2400
`define FRAME_RATE_MID    1200
`define FRAME_RATE_LOW    800
`define BASE_TICK_CYCLES  (`CLOCK_HZ / `FRAME_RATE_HIGH)
`define PORT_IDLE_US      1000
`define PORT_IDLE_CYCLES  (`PORT_IDLE_US * (`CLOCK_HZ / 1000000))
`define AFC_FAST_LIMIT    9'h010
`define AFC_MID_LIMIT     9'h004
`define IDLE_UNIT_SHIFT   5

`endif

/* verilog/serial_port_engine.v */
`default_nettype none

module serial_port_engine #(
	parameter IDLE_RESET = 100000
) (
	// Clock and reset
	input  wire       clock_in,
	input  wire       reset_in,
	// Pins
	input  wire       sclk_in,
	input  wire       sdio_in,
	output wire       sdio_out,
	output wire       sdio_oe_n_out,
	// Register side
	output reg  [6:0] addr_out,
	output reg  [7:0] wr_data_out,
	output reg        wr_pulse_out,
	output reg        rd_start_out,
	output reg        rd_done_out,
	input  wire [7:0] rd_data_in
);

	reg  [2:0]  sclk_q;
	reg  [1:0]  sdio_q;
	reg  [3:0]  bit_cnt_q;
	reg  [6:0]  shift_q;
	reg         reading_q;
	reg         load_pending_q;
	reg         drive_q;
	reg  [7:0]  out_q;
	reg  [31:0] idle_q;
	wire        rise = sclk_q[1] & ~sclk_q[2];
	wire        fall = ~sclk_q[1] & sclk_q[2];
	wire        din  = sdio_q[1];

	// RQ6 two-way data pin
	assign sdio_out      = out_q[7];
	assign sdio_oe_n_out = ~drive_q;

	always @(posedge clock_in)
	begin
		if (reset_in)
		begin
			sclk_q <= 3'h7;
			sdio_q <= 2'h0;
		end
		else
		begin
			sclk_q <= {sclk_q[1:0], sclk_in};
			sdio_q <= {sdio_q[0], sdio_in};
		end
	end

	always @(posedge clock_in)
	begin
		if (reset_in)
		begin
			bit_cnt_q      <= 4'h0;
			shift_q        <= 7'h00;
			reading_q      <= 1'b0;
			load_pending_q <= 1'b0;
			drive_q        <= 1'b0;
			out_q          <= 8'h00;
			idle_q         <= 32'h0;
			addr_out       <= 7'h00;
			wr_data_out    <= 8'h00;
			wr_pulse_out   <= 1'b0;
			rd_start_out   <= 1'b0;
			rd_done_out    <= 1'b0;
		end
		else
		begin
			wr_pulse_out <= 1'b0;
			rd_start_out <= 1'b0;
			rd_done_out  <= 1'b0;
			idle_q       <= (rise | fall) ? 32'h0 : idle_q + 32'h1;
			// Lost framing recovers after a quiet clock
			if (idle_q == IDLE_RESET)
			begin
				bit_cnt_q <= 4'h0;
				reading_q <= 1'b0;
				drive_q   <= 1'b0;
			end
			else if (rise)
			begin
				bit_cnt_q <= bit_cnt_q + 4'h1;
				shift_q   <= {shift_q[5:0], din};
				if (bit_cnt_q == 4'h7)
				begin
					addr_out       <= {shift_q[5:0], din};
					reading_q      <= ~shift_q[6];
					load_pending_q <= ~shift_q[6];
					rd_start_out   <= ~shift_q[6];
				end
				if (bit_cnt_q == 4'hf)
				begin
					wr_data_out  <= {shift_q, din};
					wr_pulse_out <= ~reading_q;
					rd_done_out  <= reading_q;
					reading_q    <= 1'b0;
					drive_q      <= 1'b0;
				end
			end
			else if (fall && reading_q)
			begin
				// Change data on falling edge, host samples on rising
				drive_q        <= 1'b1;
				load_pending_q <= 1'b0;
				out_q          <= load_pending_q ? rd_data_in : {out_q[6:0], 1'b0};
			end
		end
	end

endmodule // serial_port_engine

`default_nettype wire

/* verilog/optical_motion_sensor_regs.v */
// Summary of operation
// RQ1: Horizontal and vertical motion since the last report read as signed bytes at 0x03 and 0x04.
// RQ2: Pending motion pulls the motion wake output low.
// RQ3: The controller never writes an unlisted address, all of which are reserved.
// RQ4: Frame rate adapts among 2400, 1200 and 800 frames per second, slower for slower motion.
// RQ5: All setup and all readout pass through the register map on the serial port.
// RQ6: The controller supplies the serial clock and the single data line is two-way.
// RQ7: The 12-bit product identity sits in 0x00 and the upper nibble of 0x01, version below it.
// RQ8: Resolution is one of 600, 800, 1000, 1300 or 1600 counts per inch, 1000 after reset.
// RQ9: An idle pacing timer paces the two idle states while nothing moves.
// RQ10: Surface quality reads at 0x07 and a writable quality limit lives at 0x0d.
`include "motion_sensor_consts.vh"
`default_nettype none

module optical_motion_sensor_regs #(
	parameter [11:0] PRODUCT_IDENT    = 12'h5a3, // Arbitrary value
	parameter [3:0]  PRODUCT_VERSION  = 4'h1,    // Arbitrary value
	parameter        BASE_TICK        = `BASE_TICK_CYCLES,
	parameter        PORT_IDLE        = `PORT_IDLE_CYCLES
) (
	// Clock and reset
	input  wire        clock_in,
	input  wire        reset_in,
	// Serial port pins
	input  wire        sclk_in,
	input  wire        sdio_in,
	output wire        sdio_out,
	output wire        sdio_oe_n_out,
	// Motion wake pin
	output reg         motion_wake_out,
	// Imaging core
	output reg         frame_strobe_out,
	input  wire        sample_valid_in,
	input  wire [7:0]  sample_dx_in,
	input  wire [7:0]  sample_dy_in,
	input  wire [7:0]  sample_quality_in,
	// Status to core
	output reg  [1:0]  adaptive_frame_rate_out,
	output reg  [10:0] counts_per_inch_out,
	output reg  [3:0]  power_state_out
);

	localparam [3:0] ST_RUN   = 4'h1;
	localparam [3:0] ST_IDLE1 = 4'h2;
	localparam [3:0] ST_IDLE2 = 4'h4;
	localparam [3:0] ST_DOWN  = 4'h8;
	localparam [1:0] AFR_HIGH = 2'h0;
	localparam [1:0] AFR_MID  = 2'h1;
	localparam [1:0] AFR_LOW  = 2'h2;

	wire [6:0] addr;
	wire [7:0] wr_data;
	wire       wr_pulse;
	wire       rd_start;
	wire       rd_done;
	reg  [7:0] rd_mux;

	reg  [7:0]  power_mode_control_q;
	reg  [7:0]  sensor_setup_q;
	reg  [7:0]  write_guard_q;
	reg  [7:0]  idle_one_setup_q;
	reg  [7:0]  idle_entry_delay_q;
	reg  [7:0]  idle_two_setup_q;
	reg  [7:0]  surface_quality_limit_q;
	reg  [7:0]  surface_detect_setup_q;
	reg  [7:0]  surface_quality_q;
	reg  [7:0]  acc_x_q;
	reg  [7:0]  acc_y_q;
	reg         ovf_x_q;
	reg         ovf_y_q;
	reg  [7:0]  rd_hold_q;
	reg  [3:0]  state_q;
	reg  [3:0]  state_d;
	reg  [31:0] tick_cnt_q;
	reg         tick_q;
	reg  [5:0]  frame_div_q;
	reg  [5:0]  frame_div_lim;
	reg  [11:0] idle_pacing_timer_q;
	reg  [11:0] idle_lim_one;
	reg  [11:0] idle_lim_two;
	wire        accept;
	wire        moving;
	wire [7:0]  abs_x;
	wire [7:0]  abs_y;
	wire [8:0]  speed;
	wire        guard_open;
	wire        rd_x;
	wire        rd_y;

	// Single programming path
	// RQ5 register map access
	serial_port_engine #(
		.IDLE_RESET    (PORT_IDLE)
	) port_u (
		.clock_in      (clock_in),
		.reset_in      (reset_in),
		.sclk_in       (sclk_in),
		.sdio_in       (sdio_in),
		.sdio_out      (sdio_out),
		.sdio_oe_n_out (sdio_oe_n_out),
		.addr_out      (addr),
		.wr_data_out   (wr_data),
		.wr_pulse_out  (wr_pulse),
		.rd_start_out  (rd_start),
		.rd_done_out   (rd_done),
		.rd_data_in    (rd_hold_q)
	);

	// Drop samples when the surface looks unreliable
	// RQ10 quality gating
	assign accept = sample_valid_in & (state_q != ST_DOWN) &
		(~surface_detect_setup_q[`SDS_GATE_EN] | (sample_quality_in >= surface_quality_limit_q));
	assign moving = accept & ((sample_dx_in != 8'h00) | (sample_dy_in != 8'h00));
	assign abs_x  = sample_dx_in[7] ? (~sample_dx_in + 8'h01) : sample_dx_in;
	assign abs_y  = sample_dy_in[7] ? (~sample_dy_in + 8'h01) : sample_dy_in;
	assign speed  = {1'b0, abs_x} + {1'b0, abs_y};
	assign guard_open = (write_guard_q == `WRITE_GUARD_OPEN);
	assign rd_x = rd_done & (addr == `ADDR_HORIZONTAL_DISPLACEMENT);
	assign rd_y = rd_done & (addr == `ADDR_VERTICAL_DISPLACEMENT);

	// Saturating add of residue and new sample
	function [8:0] sat_add;
		input [7:0] acc;
		input [7:0] sub;
		input [7:0] inc;
		reg   [9:0] sum;
		begin
			sum = {acc[7], acc[7], acc} - {sub[7], sub[7], sub} + {inc[7], inc[7], inc};
			if (sum[9] && (sum[8:7] != 2'b11))
				sat_add = {1'b1, 8'h80};
			else if (!sum[9] && (sum[8:7] != 2'b00))
				sat_add = {1'b1, 8'h7f};
			else
				sat_add = {1'b0, sum[7:0]};
		end
	endfunction

	always @*
	begin
		case (addr)
			// RQ7 identity bytes
			`ADDR_PRODUCT_IDENT_HIGH:
				rd_mux = PRODUCT_IDENT[11:4];
			`ADDR_PRODUCT_IDENT_LOW_VERSION:
				rd_mux = {PRODUCT_IDENT[3:0], PRODUCT_VERSION};
			`ADDR_MOVEMENT_FLAGS:
				rd_mux = {(acc_x_q != 8'h00) | (acc_y_q != 8'h00), 2'b00, ovf_x_q, ovf_y_q, 3'b000};
			// RQ1 signed displacement
			`ADDR_HORIZONTAL_DISPLACEMENT:
				rd_mux = acc_x_q;
			`ADDR_VERTICAL_DISPLACEMENT:
				rd_mux = acc_y_q;
			`ADDR_POWER_MODE_CONTROL:
				rd_mux = power_mode_control_q;
			`ADDR_SENSOR_SETUP:
				rd_mux = sensor_setup_q;
			// RQ10 quality readout
			`ADDR_SURFACE_QUALITY:
				rd_mux = surface_quality_q;
			`ADDR_CURRENT_POWER_STATE:
				rd_mux = {2'b00, adaptive_frame_rate_out, state_q};
			`ADDR_WRITE_GUARD:
				rd_mux = write_guard_q;
			`ADDR_IDLE_ONE_SETUP:
				rd_mux = idle_one_setup_q;
			`ADDR_IDLE_ENTRY_DELAY:
				rd_mux = idle_entry_delay_q;
			`ADDR_IDLE_TWO_SETUP:
				rd_mux = idle_two_setup_q;
			`ADDR_SURFACE_QUALITY_LIMIT:
				rd_mux = surface_quality_limit_q;
			`ADDR_SURFACE_DETECT_SETUP:
				rd_mux = surface_detect_setup_q;
			default:
				rd_mux = 8'h00;
		endcase
	end

	// Snapshot at address time so the cleared amount equals what was sent
	always @(posedge clock_in)
	begin
		if (reset_in)
			rd_hold_q <= 8'h00;
		else if (rd_start)
			rd_hold_q <= rd_mux;
	end

	// Writable registers; idle setup is locked unless the guard is open
	always @(posedge clock_in)
	begin
		if (reset_in)
		begin
			power_mode_control_q    <= `RST_POWER_MODE_CONTROL;
			sensor_setup_q          <= `RST_SENSOR_SETUP;
			write_guard_q           <= `RST_WRITE_GUARD;
			idle_one_setup_q        <= `RST_IDLE_ONE_SETUP;
			idle_entry_delay_q      <= `RST_IDLE_ENTRY_DELAY;
			idle_two_setup_q        <= `RST_IDLE_TWO_SETUP;
			surface_quality_limit_q <= `RST_SURFACE_QUALITY_LIMIT;
			surface_detect_setup_q  <= `RST_SURFACE_DETECT_SETUP;
		end
		else if (wr_pulse)
		begin
			// RQ3 reserved writes ignored
			case (addr)
				`ADDR_POWER_MODE_CONTROL:
					power_mode_control_q <= wr_data;
				`ADDR_SENSOR_SETUP:
					sensor_setup_q <= wr_data;
				`ADDR_WRITE_GUARD:
					write_guard_q <= wr_data;
				`ADDR_IDLE_ONE_SETUP:
					if (guard_open)
						idle_one_setup_q <= wr_data;
				`ADDR_IDLE_ENTRY_DELAY:
					if (guard_open)
						idle_entry_delay_q <= wr_data;
				`ADDR_IDLE_TWO_SETUP:
					if (guard_open)
						idle_two_setup_q <= wr_data;
				// RQ10 writable limit
				`ADDR_SURFACE_QUALITY_LIMIT:
					if (guard_open)
						surface_quality_limit_q <= wr_data;
				`ADDR_SURFACE_DETECT_SETUP:
					if (guard_open)
						surface_detect_setup_q <= wr_data;
				default:
					write_guard_q <= write_guard_q;
			endcase
		end
	end

	// Motion accumulation; a new sample in the read-clear cycle is kept
	always @(posedge clock_in)
	begin : motion_acc
		reg [8:0] nx;
		reg [8:0] ny;
		nx = sat_add(acc_x_q, rd_x ? rd_hold_q : 8'h00, accept ? sample_dx_in : 8'h00);
		ny = sat_add(acc_y_q, rd_y ? rd_hold_q : 8'h00, accept ? sample_dy_in : 8'h00);
		if (reset_in)
		begin
			acc_x_q           <= 8'h00;
			acc_y_q           <= 8'h00;
			ovf_x_q           <= 1'b0;
			ovf_y_q           <= 1'b0;
			surface_quality_q <= 8'h00;
		end
		else
		begin
			// RQ1 report and clear
			acc_x_q <= nx[7:0];
			acc_y_q <= ny[7:0];
			ovf_x_q <= nx[8] | (ovf_x_q & ~rd_x);
			ovf_y_q <= ny[8] | (ovf_y_q & ~rd_y);
			if (sample_valid_in)
				surface_quality_q <= sample_quality_in;
		end
	end

	// Active low wake while motion waits to be read
	always @(posedge clock_in)
	begin
		if (reset_in)
			motion_wake_out <= 1'b1;
		else
			// RQ2 wake low on motion
			motion_wake_out <= ~((acc_x_q != 8'h00) | (acc_y_q != 8'h00) | ovf_x_q | ovf_y_q);
	end

	// RQ8 resolution select
	always @(posedge clock_in)
	begin
		if (reset_in)
			counts_per_inch_out <= 11'd1000;
		else
		begin
			case (sensor_setup_q[2:0])
				`CPI_600:  counts_per_inch_out <= 11'd600;
				`CPI_800:  counts_per_inch_out <= 11'd800;
				`CPI_1000: counts_per_inch_out <= 11'd1000;
				`CPI_1300: counts_per_inch_out <= 11'd1300;
				`CPI_1600: counts_per_inch_out <= 11'd1600;
				default:   counts_per_inch_out <= counts_per_inch_out;
			endcase
		end
	end

	// Base tick at the highest frame rate
	always @(posedge clock_in)
	begin
		if (reset_in)
		begin
			tick_cnt_q <= 32'h0;
			tick_q     <= 1'b0;
		end
		else
		begin
			tick_q     <= (tick_cnt_q == BASE_TICK - 1);
			tick_cnt_q <= (tick_cnt_q == BASE_TICK - 1) ? 32'h0 : tick_cnt_q + 32'h1;
		end
	end

	// RQ4 speed to rate
	always @(posedge clock_in)
	begin
		if (reset_in)
			adaptive_frame_rate_out <= AFR_HIGH;
		else if (!power_mode_control_q[`PMC_ADAPTIVE_EN])
			adaptive_frame_rate_out <= AFR_HIGH;
		else if (accept)
		begin
			if (speed >= `AFC_FAST_LIMIT)
				adaptive_frame_rate_out <= AFR_HIGH;
			else if (speed >= `AFC_MID_LIMIT)
				adaptive_frame_rate_out <= AFR_MID;
			else
				adaptive_frame_rate_out <= AFR_LOW;
		end
	end

	// Base ticks per frame, less one; idle states stretch it by their nibble
	always @*
	begin
		case (state_q)
			ST_RUN:
			begin
				case (adaptive_frame_rate_out)
					AFR_MID: frame_div_lim = 6'd1;
					AFR_LOW: frame_div_lim = 6'd2;
					default: frame_div_lim = 6'd0;
				endcase
			end
			// RQ4 lowest rate base
			ST_IDLE1: frame_div_lim = {idle_one_setup_q[7:4], 2'b11};
			ST_IDLE2: frame_div_lim = {idle_two_setup_q[7:4], 2'b11};
			default:  frame_div_lim = 6'd0;
		endcase
	end

	always @(posedge clock_in)
	begin
		if (reset_in)
		begin
			frame_div_q      <= 6'd0;
			frame_strobe_out <= 1'b0;
		end
		else
		begin
			frame_strobe_out <= 1'b0;
			if (tick_q)
			begin
				frame_div_q <= (frame_div_q >= frame_div_lim) ? 6'd0 : frame_div_q + 6'd1;
				frame_strobe_out <= (frame_div_q >= frame_div_lim) && (state_q != ST_DOWN);
			end
		end
	end

	// Idle thresholds in units of base ticks
	always @*
	begin
		idle_lim_one = {idle_entry_delay_q[7:4], 8'h00} >> (8 - `IDLE_UNIT_SHIFT);
		idle_lim_two = idle_lim_one + ({idle_entry_delay_q[3:0], 8'h00} >> (8 - `IDLE_UNIT_SHIFT));
	end

	// RQ9 idle pacing timer
	always @(posedge clock_in)
	begin
		if (reset_in)
			idle_pacing_timer_q <= 12'h000;
		else if (moving || state_q == ST_DOWN)
			idle_pacing_timer_q <= 12'h000;
		else if (tick_q && idle_pacing_timer_q != 12'hfff)
			idle_pacing_timer_q <= idle_pacing_timer_q + 12'h001;
	end

	// RQ9 idle state walk
	always @*
	begin
		case (state_q)
			ST_RUN:
				if (power_mode_control_q[`PMC_POWER_DOWN])
					state_d = ST_DOWN;
				else if (power_mode_control_q[`PMC_IDLE_ONE_EN] && idle_pacing_timer_q >= idle_lim_one)
					state_d = ST_IDLE1;
				else
					state_d = ST_RUN;
			ST_IDLE1:
				if (power_mode_control_q[`PMC_POWER_DOWN])
					state_d = ST_DOWN;
				else if (moving || !power_mode_control_q[`PMC_IDLE_ONE_EN])
					state_d = ST_RUN;
				else if (power_mode_control_q[`PMC_IDLE_TWO_EN] && idle_pacing_timer_q >= idle_lim_two)
					state_d = ST_IDLE2;
				else
					state_d = ST_IDLE1;
			ST_IDLE2:
				if (power_mode_control_q[`PMC_POWER_DOWN])
					state_d = ST_DOWN;
				else if (moving || !power_mode_control_q[`PMC_IDLE_TWO_EN])
					state_d = ST_RUN;
				else
					state_d = ST_IDLE2;
			ST_DOWN:
				state_d = power_mode_control_q[`PMC_POWER_DOWN] ? ST_DOWN : ST_RUN;
			default:
				state_d = ST_RUN;
		endcase
	end

	always @(posedge clock_in)
	begin
		if (reset_in)
		begin
			state_q         <= ST_RUN;
			power_state_out <= ST_RUN;
		end
		else
		begin
			state_q         <= state_d;
			power_state_out <= state_d;
		end
	end

endmodule // optical_motion_sensor_regs

`default_nettype wire

/* bench/optical_motion_sensor_regs_properties.sv */
`default_nettype none
module optical_motion_sensor_regs_checker (
	input wire logic        clock_in,
	input wire logic        reset_in,
	input wire logic        sdio_oe_n_out,
	input wire logic        motion_wake_out,
	input wire logic        frame_strobe_out,
	input wire logic        sample_valid_in,
	input wire logic [7:0]  sample_dx_in,
	input wire logic [7:0]  sample_quality_in,
	input wire logic [1:0]  adaptive_frame_rate_out,
	input wire logic [10:0] counts_per_inch_out,
	input wire logic [3:0]  power_state_out
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (reset_in);

	property p_cpi_legal;
		counts_per_inch_out inside {11'h258, 11'h320, 11'h3e8, 11'h514, 11'h640};
	endproperty
	a_cpi_legal: assert property (p_cpi_legal) else $error("resolution out of range");
	property p_cpi_reset;
		$fell(reset_in) |-> counts_per_inch_out == 11'h3e8;
	endproperty
	a_cpi_reset: assert property (p_cpi_reset) else $error("resolution not default after reset");
	property p_rate_legal;
		adaptive_frame_rate_out != 2'h3;
	endproperty
	a_rate_legal: assert property (p_rate_legal) else $error("frame rate level out of range");
	property p_strobe_pulse;
		frame_strobe_out |=> !frame_strobe_out;
	endproperty
	a_strobe_pulse: assert property (p_strobe_pulse) else $error("frame strobe longer than a cycle");
	property p_wake_reset;
		$fell(reset_in) |-> motion_wake_out;
	endproperty
	a_wake_reset: assert property (p_wake_reset) else $error("wake low after reset");
	// Full quality passes any limit
	property p_wake_motion;
		sample_valid_in && motion_wake_out && power_state_out != 4'h8 && sample_quality_in == 8'hff
			&& sample_dx_in != 8'h00 |-> ##[1:3] !motion_wake_out;
	endproperty
	a_wake_motion: assert property (p_wake_motion) else $error("motion did not pull wake low");
	property p_oe_reset;
		$fell(reset_in) |-> sdio_oe_n_out;
	endproperty
	a_oe_reset: assert property (p_oe_reset) else $error("data pin driven after reset");
	property p_state_onehot;
		$onehot(power_state_out);
	endproperty
	a_state_onehot: assert property (p_state_onehot) else $error("power state not one-hot");
	property p_pd_quiet;
		power_state_out == 4'h8 && $past(power_state_out) == 4'h8 |-> !frame_strobe_out;
	endproperty
	a_pd_quiet: assert property (p_pd_quiet) else $error("frame strobe in power down");
endmodule // optical_motion_sensor_regs_checker

bind optical_motion_sensor_regs optical_motion_sensor_regs_checker u_checker (
	.clock_in                (clock_in),
	.reset_in                (reset_in),
	.sdio_oe_n_out           (sdio_oe_n_out),
	.motion_wake_out         (motion_wake_out),
	.frame_strobe_out        (frame_strobe_out),
	.sample_valid_in         (sample_valid_in),
	.sample_dx_in            (sample_dx_in),
	.sample_quality_in       (sample_quality_in),
	.adaptive_frame_rate_out (adaptive_frame_rate_out),
	.counts_per_inch_out     (counts_per_inch_out),
	.power_state_out         (power_state_out)
);
`default_nettype wire

/* bench/mouse_controller_model.sv */
`default_nettype none
module mouse_controller_model (
	input  wire logic       clock_in,
	input  wire logic       sdio_in,
	output var  logic       sclk_out,
	output var  logic       sdio_out,
	output var  logic       sdio_en_out,
	output var  logic       rd_done_out,
	output var  logic [7:0] rd_byte_out
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		sclk_out = 1'b1;
		sdio_out = 1'b0;
		sdio_en_out = 1'b0;
		rd_done_out = 1'b0;
		rd_byte_out = 8'h00;
	end

	task automatic half(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask

	task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] data);
		logic [15:0] word;
		word = {wr, addr, data};
		if (wr && addr > 7'h0e)
			return;
		for (int i = 15; i >= 0; i--)
		begin
			sclk_out = 1'b0;
			// Line let go before the device turns it round
			sdio_en_out = wr || i > 7;
			sdio_out = word[i];
			half(4);
			sclk_out = 1'b1;
			half(2);
			if (i < 8)
				rd_byte_out[i] = sdio_in;
			half(2);
		end
		sdio_en_out = 1'b0;
		if (!wr)
		begin
			rd_done_out = 1'b1;
			half(1);
			rd_done_out = 1'b0;
		end
		half(4);
	endtask
endmodule // mouse_controller_model
`default_nettype wire

/* bench/optical_motion_sensor_regs_tb_top.sv */
`default_nettype none
module optical_motion_sensor_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// Identity values are arbitrary
	localparam logic [11:0] IDENT   = 12'h6c4;
	localparam logic [3:0]  VERSION = 4'h2;
	localparam int          TICK    = 20;
	localparam logic [15:0] RST_TAB [8] = '{16'h05b8, 16'h0602, 16'h0900, 16'h0a70,
		16'h0b10, 16'h0c70, 16'h0d0a, 16'h0ee5};
	localparam logic [10:0] CPI_TAB [6] = '{11'h258, 11'h320, 11'h3e8, 11'h514, 11'h640, 11'h640};

	logic        clock_in = 1'b0;
	logic        reset_in = 1'b1;
	logic        sclk, host_bit, host_en, rd_done, float_q = 1'b0;
	logic        sdio_out, sdio_oe_n_out, wake, strobe;
	logic        sample_valid = 1'b0;
	logic [7:0]  dx = 8'h00, dy = 8'h00, quality = 8'hff, rd_byte;
	logic [1:0]  rate;
	logic [10:0] counts_per_inch;
	logic [3:0]  state;
	logic [7:0]  expect_q [$];
	int          errors = 0;
	int          total_checks = 0;
	int          seed = 32'hf60acac2;
	int          sum_x, sum_y;
	// Released line shows a changing pattern, not the last bit
	wire         sdio_line = !sdio_oe_n_out ? sdio_out : host_en ? host_bit : float_q;

	always #5 clock_in = ~clock_in;
	always @(posedge clock_in) float_q <= ~float_q;

	optical_motion_sensor_regs #(.PRODUCT_IDENT(IDENT), .PRODUCT_VERSION(VERSION), .BASE_TICK(TICK),
		.PORT_IDLE(200)) dut (
		.clock_in                (clock_in),
		.reset_in                (reset_in),
		.sclk_in                 (sclk),
		.sdio_in                 (sdio_line),
		.sdio_out                (sdio_out),
		.sdio_oe_n_out           (sdio_oe_n_out),
		.motion_wake_out         (wake),
		.frame_strobe_out        (strobe),
		.sample_valid_in         (sample_valid),
		.sample_dx_in            (dx),
		.sample_dy_in            (dy),
		.sample_quality_in       (quality),
		.adaptive_frame_rate_out (rate),
		.counts_per_inch_out     (counts_per_inch),
		.power_state_out         (state)
	);

	mouse_controller_model u_host (
		.clock_in    (clock_in),
		.sdio_in     (sdio_line),
		.sclk_out    (sclk),
		.sdio_out    (host_bit),
		.sdio_en_out (host_en),
		.rd_done_out (rd_done),
		.rd_byte_out (rd_byte)
	);

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d, errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask

	task automatic reg_read(input logic [6:0] a, input logic [7:0] exp);
		expect_q.push_back(exp);
		u_host.xfer(1'b0, a, 8'h00);
	endtask

	task automatic sample(input logic [7:0] x, input logic [7:0] y, input logic [7:0] qual);
		dx = x;
		dy = y;
		quality = qual;
		sample_valid = 1'b1;
		cycles(1);
		sample_valid = 1'b0;
		cycles(3);
	endtask

	task automatic wait_state(input logic [3:0] want, input int limit);
		int n;
		n = 0;
		while (state !== want && n < limit)
		begin
			cycles(1);
			n++;
		end
		check("power state", 16'(state), 16'(want));
		if (state !== want)
			stop_test();
	endtask

	// Spacing between two frame strobes, in clocks
	task automatic strobe_gap(input int want);
		int n;
		n = 0;
		while (strobe !== 1'b1 && n < 200)
		begin
			cycles(1);
			n++;
		end
		n = 0;
		cycles(1);
		while (strobe !== 1'b1 && n < 200)
		begin
			cycles(1);
			n++;
		end
		check("frame spacing", 16'(n + 1), 16'(want));
	endtask

	always @(posedge clock_in)
	begin
		if (rd_done)
		begin
			if (expect_q.size() == 0)
				check("unplanned read", 16'h0001, 16'h0000);
			else
				check("register read", 16'(rd_byte), 16'(expect_q.pop_front()));
		end
	end

	initial
	begin
		cycles(100000);
		check("run time", 16'h0001, 16'h0000);
		stop_test();
	end

	initial
	begin
		logic [7:0] rx;
		logic [7:0] ry;
		cycles(5);
		reset_in = 1'b0;
		cycles(5);
		check("resolution after reset", 16'(counts_per_inch), 16'h03e8);
		wait_state(4'h1, 1);
		reg_read(7'h00, IDENT[11:4]);
		reg_read(7'h01, {IDENT[3:0], VERSION});
		for (int i = 0; i < 8; i++)
			reg_read(RST_TAB[i][14:8], RST_TAB[i][7:0]);
		reg_read(7'h3c, 8'h00);
		u_host.xfer(1'b1, 7'h00, 8'hff);
		reg_read(7'h00, IDENT[11:4]);
		for (int c = 0; c < 6; c++)
		begin
			u_host.xfer(1'b1, 7'h06, 8'(c));
			cycles(2);
			check("resolution", 16'(counts_per_inch), 16'(CPI_TAB[c]));
		end
		// Guarded limit ignored while locked
		u_host.xfer(1'b1, 7'h0d, 8'h40);
		reg_read(7'h0d, 8'h0a);
		u_host.xfer(1'b1, 7'h09, 8'h5a);
		u_host.xfer(1'b1, 7'h0d, 8'h40);
		u_host.xfer(1'b1, 7'h0b, 8'h11);
		reg_read(7'h0d, 8'h40);
		sample(8'h05, 8'h05, 8'h30);
		check("wake after rejected frame", 16'(wake), 16'h0001);
		sum_x = 0;
		sum_y = 0;
		for (int k = 0; k < 6; k++)
		begin
			rx = 8'($random(seed) % 8);
			ry = 8'($random(seed) % 8);
			sum_x += $signed(rx);
			sum_y += $signed(ry);
			sample(rx, ry, 8'hc0);
		end
		check("wake with residue", 16'(wake), 16'(sum_x == 0 && sum_y == 0));
		reg_read(7'h03, 8'(sum_x));
		reg_read(7'h04, 8'(sum_y));
		reg_read(7'h07, 8'hc0);
		cycles(2);
		check("wake after readout", 16'(wake), 16'h0001);
		sample(8'h14, 8'h00, 8'hff);
		check("fast rate", 16'(rate), 16'h0000);
		strobe_gap(TICK);
		sample(8'h02, 8'hfe, 8'hff);
		check("middle rate", 16'(rate), 16'h0001);
		strobe_gap(2 * TICK);
		sample(8'h01, 8'h01, 8'hff);
		check("slow rate", 16'(rate), 16'h0002);
		strobe_gap(3 * TICK);
		reg_read(7'h02, 8'h80);
		u_host.xfer(1'b1, 7'h05, 8'hb9);
		wait_state(4'h8, 20);
		cycles(60);
		u_host.xfer(1'b1, 7'h05, 8'hb8);
		wait_state(4'h1, 20);
		wait_state(4'h2, 1500);
		wait_state(4'h4, 1500);
		sample(8'h03, 8'h00, 8'hff);
		wait_state(4'h1, 10);
		cycles(20);
		check("pending reads", 16'(expect_q.size()), 16'h0000);
		stop_test();
	end
endmodule // optical_motion_sensor_regs_tb_top
`default_nettype wire
